/* File: hdl/ipr_field_bit.sv */
`timescale 1ns/100ps
`default_nettype none
module ipr_field_bit #(
    parameter bit IMPLEMENTED = 1'b1,
    parameter bit WRITABLE    = 1'b1,
    parameter bit RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // software write
    input  wire logic write_enable,
    input  wire logic write_data,
    // stored value
    output var  logic value
);

    generate
        if (IMPLEMENTED) begin : g_impl
            logic next_value;

            always_comb begin
                next_value = value;
                if (!reset_n) begin
                    next_value = RESET_VALUE;
                end else if (WRITABLE && write_enable) begin
                    next_value = write_data;
                end
            end

            always_ff @(posedge clock) begin
                value <= next_value;
            end

            // read-only cells never move once out of reset
            if (!WRITABLE) begin : g_ro
                chk_cell_readonly_hold: assert property (
                    @(posedge clock) disable iff (!reset_n) $past(reset_n) |-> value == RESET_VALUE)
                    else $error("read-only priority cell left its reset value");
            end
        end else begin : g_unimpl
            // unimplemented positions carry no storage
            assign value = 1'b0;
        end
    endgenerate

endmodule
`default_nettype wire

/* File: hdl/ipr_reg3_apb.sv */
`timescale 1ns/100ps
`default_nettype none
module ipr_reg3_apb #(
    parameter int ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ADDR_WIDTH-1:0]         paddr,
    input  wire logic [ipr_pkg::DATA_WIDTH-1:0] pwdata,
    input  wire logic [ipr_pkg::STRB_WIDTH-1:0] pstrb,
    output var  logic [ipr_pkg::DATA_WIDTH-1:0] prdata,
    output var  logic                          pready,
    output var  logic                          pslverr,
    // priority selects toward the interrupt logic
    output var  logic [ipr_pkg::REG_WIDTH-1:0] priority_levels,
    output var  logic                          display_irq_priority,
    output var  logic                          serial_rx_irq_priority,
    output var  logic                          serial_tx_irq_priority,
    output var  logic                          capcomp_b_irq_priority,
    output var  logic                          capcomp_a_irq_priority
);

    generate
        if (ADDR_WIDTH < 3 || ADDR_WIDTH > 32) begin : g_bad_width
            $error("ipr_reg3_apb: ADDR_WIDTH must lie between 3 and 32");
        end
    endgenerate

    localparam logic [ADDR_WIDTH-3:0] REG3_WORD = ipr_pkg::REG3_OFFSET[ADDR_WIDTH-1:2];

    ipr_pkg::ipr_bus_state_type        state;
    ipr_pkg::ipr_bus_state_type        next_state;
    logic [ipr_pkg::DATA_WIDTH-1:0]    next_prdata;
    logic                              addr_error;
    logic                              next_addr_error;

    logic                              reg3_hit;
    logic                              setup_phase;
    logic                              access_done;
    logic                              reg3_write;
    logic [ipr_pkg::REG_WIDTH-1:0]     reg3_value;

    // -------- address decode --------

    assign reg3_hit    = (paddr[ADDR_WIDTH-1:2] == REG3_WORD);
    assign setup_phase = psel && !penable;

    // -------- handshake --------

    // zero-wait slave: the first access-phase cycle completes the transfer
    always_comb begin
        pready  = (state == ipr_pkg::IPR_ST_ACCESS) && psel && penable;
        pslverr = pready && addr_error;
    end

    assign access_done = pready;

    // byte lane 0 holds the whole register, other lanes are ignored
    assign reg3_write = access_done && pwrite && reg3_hit && pstrb[0];

    // -------- bus state, read data and error flag --------

    always_comb begin
        next_state      = state;
        next_prdata     = prdata;
        next_addr_error = addr_error;
        if (!reset_n) begin
            next_state      = ipr_pkg::IPR_ST_IDLE;
            next_prdata     = '0;
            next_addr_error = 1'b0;
        end else begin
            case (state)
                ipr_pkg::IPR_ST_IDLE: begin
                    if (setup_phase) begin
                        next_state      = ipr_pkg::IPR_ST_ACCESS;
                        next_addr_error = !reg3_hit;
                        next_prdata     = '0;
                        if (!pwrite && reg3_hit) begin
                            // upper bits of the word read as zero
                            next_prdata[ipr_pkg::REG_WIDTH-1:0] = reg3_value;
                        end
                    end
                end
                ipr_pkg::IPR_ST_ACCESS: begin
                    if (access_done) begin
                        next_state = ipr_pkg::IPR_ST_IDLE;
                    end else if (!psel) begin
                        // master dropped the transfer; resynchronise
                        next_state = ipr_pkg::IPR_ST_IDLE;
                    end
                end
                default: begin
                    next_state = ipr_pkg::IPR_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        state      <= next_state;
        prdata     <= next_prdata;
        addr_error <= next_addr_error;
    end

    // -------- register cells --------

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < ipr_pkg::REG_WIDTH; bit_idx++) begin : g_cell
            // writable mask keeps read-only and absent bits out of the write path
            ipr_field_bit #(
                .IMPLEMENTED (ipr_pkg::REG3_IMPL_MASK[bit_idx]),
                .WRITABLE    (ipr_pkg::REG3_WRITE_MASK[bit_idx]),
                .RESET_VALUE (ipr_pkg::REG3_RESET_VALUE[bit_idx])
            ) u_cell (
                .clock        (clock),
                .reset_n      (reset_n),
                .write_enable (reg3_write),
                .write_data   (pwdata[bit_idx]),
                .value        (reg3_value[bit_idx])
            );
        end
    endgenerate

    // -------- priority outputs --------

    assign priority_levels        = reg3_value;
    assign display_irq_priority   = reg3_value[ipr_pkg::DISPLAY_BIT];
    assign serial_rx_irq_priority = reg3_value[ipr_pkg::SERIAL_RX_BIT];
    assign serial_tx_irq_priority = reg3_value[ipr_pkg::SERIAL_TX_BIT];
    assign capcomp_b_irq_priority = reg3_value[ipr_pkg::CAPCOMP_B_BIT];
    assign capcomp_a_irq_priority = reg3_value[ipr_pkg::CAPCOMP_A_BIT];

    // -------- checks --------

    sequence seq_setup;
        psel && !penable;
    endsequence

    sequence seq_access;
        psel && penable && pready;
    endsequence

    sequence seq_reg3_write;
        psel && penable && pready && pwrite && reg3_hit && pstrb[0];
    endsequence

    sequence seq_reg3_read;
        psel && !penable && !pwrite && reg3_hit ##1 psel && penable && pready;
    endsequence

    // a write to the register word whose low byte lane is off
    sequence seq_gated_write;
        psel && penable && pready && pwrite && reg3_hit && !pstrb[0];
    endsequence

    sequence seq_unmapped_setup;
        psel && !penable && !reg3_hit;
    endsequence

    sequence seq_unmapped_write;
        psel && !penable && pwrite && !reg3_hit ##1 psel && penable && pready;
    endsequence

    sequence seq_unmapped_read;
        psel && !penable && !pwrite && !reg3_hit ##1 psel && penable && pready;
    endsequence

    sequence seq_mapped_setup;
        psel && !penable && reg3_hit;
    endsequence

    sequence seq_write_setup;
        psel && !penable && pwrite;
    endsequence

    chk_reset_load_value: assert property (
        @(posedge clock)
        !reset_n |=> reg3_value == ipr_pkg::REG3_RESET_VALUE)
        else $error("priority register did not load its reset value");

    chk_reset_bus_idle: assert property (
        @(posedge clock)
        !reset_n |=> !pready && !pslverr && prdata == 32'h0000_0000)
        else $error("bus outputs not idle after reset");

    chk_serial_rx_steady: assert property (
        @(posedge clock) disable iff (!reset_n)
        serial_rx_irq_priority == 1'b1)
        else $error("serial receive priority bit left one");

    chk_serial_tx_steady: assert property (
        @(posedge clock) disable iff (!reset_n)
        serial_tx_irq_priority == 1'b1)
        else $error("serial transmit priority bit left one");

    chk_readonly_mask_set: assert property (
        @(posedge clock) disable iff (!reset_n)
        (reg3_value & ipr_pkg::REG3_READONLY_MASK) == ipr_pkg::REG3_READONLY_MASK)
        else $error("a read-only priority bit was cleared");

    chk_serial_rx_fixed: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata[ipr_pkg::SERIAL_RX_BIT] == 1'b1)
        else $error("serial receive priority bit did not read as one");

    chk_serial_tx_fixed: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_write |=> serial_tx_irq_priority == 1'b1 && $stable(serial_tx_irq_priority))
        else $error("write moved the serial transmit priority bit");

    chk_serial_tx_read: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata[ipr_pkg::SERIAL_TX_BIT] == 1'b1)
        else $error("serial transmit priority bit did not read as one");

    chk_display_bit_write: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_write |=> display_irq_priority == $past(pwdata[ipr_pkg::DISPLAY_BIT]))
        else $error("display priority bit did not take the written value");

    chk_capcomp_write: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_write |=> {capcomp_b_irq_priority, capcomp_a_irq_priority}
                           == $past(pwdata[ipr_pkg::CAPCOMP_B_BIT:ipr_pkg::CAPCOMP_A_BIT]))
        else $error("capture/compare priority bits did not take the written value");

    chk_display_read_back: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata[ipr_pkg::DISPLAY_BIT] == display_irq_priority)
        else $error("display priority bit read back wrong");

    chk_capcomp_read_back: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata[ipr_pkg::CAPCOMP_B_BIT] == capcomp_b_irq_priority
                          && prdata[ipr_pkg::CAPCOMP_A_BIT] == capcomp_a_irq_priority)
        else $error("capture/compare priority bits read back wrong");

    chk_read_whole_value: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata == {24'h00_0000, reg3_value})
        else $error("read data differs from the stored register");

    chk_idle_holds_value: assert property (
        @(posedge clock) disable iff (!reset_n)
        $past(reset_n) && !$past(reg3_write) |-> $stable(reg3_value))
        else $error("priority register changed without a write");

    chk_gated_write_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_gated_write |=> $stable(reg3_value))
        else $error("write with low byte lane off changed the register");

    chk_unmapped_write_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_unmapped_write |=> $stable(reg3_value))
        else $error("unmapped write changed the register");

    chk_unimpl_read_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> (prdata & ~{24'h00_0000, ipr_pkg::REG3_IMPL_MASK}) == 32'h0000_0000)
        else $error("unimplemented or upper bits read as nonzero");

    chk_unimpl_store_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_write |=> (reg3_value & ~ipr_pkg::REG3_IMPL_MASK) == 8'h00)
        else $error("write reached an unimplemented bit");

    chk_unimpl_always_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        (reg3_value & ~ipr_pkg::REG3_IMPL_MASK) == 8'h00)
        else $error("an unimplemented bit holds a one");

    chk_upper_read_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_reg3_read |-> prdata[ipr_pkg::DATA_WIDTH-1:ipr_pkg::REG_WIDTH] == 24'h00_0000)
        else $error("upper read data bits not zero");

    chk_zero_wait_ready: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_setup ##1 (psel && penable) |-> pready)
        else $error("slave did not answer in the first access cycle");

    chk_unmapped_error: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_unmapped_setup ##1 seq_access |-> pslverr)
        else $error("unmapped access not flagged as error");

    chk_ready_single_cycle: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_access |=> !pready)
        else $error("ready stayed high after the access cycle");

    chk_mapped_no_error: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_mapped_setup ##1 seq_access |-> !pslverr)
        else $error("register access flagged as error");

    chk_unmapped_read_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_unmapped_read |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    chk_prdata_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_setup ##1 seq_access |=> $stable(prdata))
        else $error("read data moved before the next setup");

    chk_write_prdata_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        seq_write_setup ##1 seq_access |-> prdata == 32'h0000_0000)
        else $error("read data not cleared during a write");

endmodule
`default_nettype wire

/* File: shared/ipr_pkg.sv */
// Overview of operation
// - The display interrupt priority bit sits at bit 6, software may read and write it, and reset sets it to one.
// - The serial receive priority bit sits at bit 5, reads as one after reset and no software write changes it.
// - The serial transmit priority bit sits at bit 4, reads as one after reset and no software write changes it.
// - Bits 7, 3 and 0 are not implemented, always read as zero and ignore every write.
`default_nettype none
package ipr_pkg;

    // byte address of the one priority register on the bus
    localparam logic [31:0] REG3_OFFSET          = 32'h0000_0000;

    // bit positions inside the register
    localparam int          DISPLAY_BIT          = 6;
    localparam int          SERIAL_RX_BIT        = 5;
    localparam int          SERIAL_TX_BIT        = 4;
    localparam int          CAPCOMP_B_BIT        = 2;
    localparam int          CAPCOMP_A_BIT        = 1;

    // per-bit layout and value after reset
    localparam logic [7:0]  REG3_RESET_VALUE     = 8'h76;
    localparam logic [7:0]  REG3_IMPL_MASK       = 8'h76;
    localparam logic [7:0]  REG3_WRITE_MASK      = 8'h46;
    localparam logic [7:0]  REG3_READONLY_MASK   = 8'h30;

    localparam int          REG_WIDTH            = 8;
    localparam int          DATA_WIDTH           = 32;
    localparam int          STRB_WIDTH           = 4;

    // cycles from the first access-phase cycle to pready
    localparam int          ACCESS_WAIT_CYCLES   = 0;

    typedef enum logic [1:0] {
        IPR_ST_IDLE   = 2'b01,
        IPR_ST_ACCESS = 2'b10
    } ipr_bus_state_type;

endpackage
`default_nettype wire

/* File: sim/peripheral_irq_priority_reg3_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_priority_reg3_bench;
    logic        clock;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  priority_levels;
    logic        display_irq_priority;
    logic        serial_rx_irq_priority;
    logic        serial_tx_irq_priority;
    logic        capcomp_b_irq_priority;
    logic        capcomp_a_irq_priority;
    logic        timed_out;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  pat [7];
    logic [11:0] bad_addr [2];
    int          bad_count;
    int          checks_done;

    ipr_reg3_apb i_dut (
        .clock                  (clock),
        .reset_n                (reset_n),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .pstrb                  (pstrb),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .priority_levels        (priority_levels),
        .display_irq_priority   (display_irq_priority),
        .serial_rx_irq_priority (serial_rx_irq_priority),
        .serial_tx_irq_priority (serial_tx_irq_priority),
        .capcomp_b_irq_priority (capcomp_b_irq_priority),
        .capcomp_a_irq_priority (capcomp_a_irq_priority)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        checks_done++;
        if (seen !== expected) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            timed_out = 1'b1;
        end
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check_state(input logic [7:0] e);
        #1;
        check({24'h00_0000, priority_levels}, {24'h00_0000, e});
        check({27'h000_0000, display_irq_priority, serial_rx_irq_priority, serial_tx_irq_priority,
               capcomp_b_irq_priority, capcomp_a_irq_priority},
              {27'h000_0000, e[6], e[5], e[4], e[2], e[1]});
    endtask

    task automatic read_expect(input logic [7:0] e);
        xfer(1'b0, 12'h000, 32'h0000_0000, 4'h0, rd, er);
        check(rd, {24'h00_0000, e});
        check({31'h0000_0000, er}, 32'h0000_0000);
        check_state(e);
    endtask

    // a stuck handshake ends the run from here
    always @(posedge clock) begin
        if (timed_out) wrap_up();
    end

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        timed_out = 1'b0;
        bad_count = 0;
        checks_done = 0;
        pat = '{8'hff, 8'h00, 8'h40, 8'h06, 8'h02, 8'h04, 8'h89};
        bad_addr = '{12'h004, 12'hffc};
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        read_expect(8'h76);
        $display("test reset_values done");
        // only bits 6, 2, 1 follow a write; 5 and 4 stay one, 7, 3, 0 stay zero
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, 12'h000, {24'hff_ffff, pat[i]}, 4'hf, rd, er);
            check_state((pat[i] & 8'h46) | 8'h30);
            read_expect((pat[i] & 8'h46) | 8'h30);
        end
        $display("test write_patterns done");
        xfer(1'b1, 12'h000, 32'hffff_ffff, 4'he, rd, er);
        read_expect(8'h30);
        $display("test lane_gate done");
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, bad_addr[i], 32'hffff_ffff, 4'hf, rd, er);
            check({31'h0000_0000, er}, 32'h0000_0001);
            xfer(1'b0, bad_addr[i], 32'h0000_0000, 4'h0, rd, er);
            check(rd, 32'h0000_0000);
            check({31'h0000_0000, er}, 32'h0000_0001);
            read_expect(8'h30);
        end
        $display("test unmapped done");
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        reset_n <= 1'b1;
        read_expect(8'h76);
        $display("test second_reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
